//--- core/lwps_pkg.sv
// Shared constants and types for the late-write pipelined memory and its host.
package lwps_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 18;
  localparam int DEPTH = 1048576;
  localparam int LANE_A_HI = 8;
  localparam int LANE_B_LO = 9;
  // ==========================================================================
  // Pipeline timing, in clock cycles.
  localparam int PIPE_LAT = 2;
  // ==========================================================================
  // Host command register layout and encodings.
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_BURST = 2'h3;
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  localparam int CMD_LO = 0;
  localparam int CMD_HI = 1;
  localparam int CMD_BW_LO = 2;
  localparam int CMD_BW_HI = 3;
  localparam int CTRL_ORDER = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_OE = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam int FIFO_DEPTH = 8;
  // One pipeline stage of the memory.
  typedef struct packed {
    logic valid;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [1:0] bw_n;
  } lwps_stage_t;
  // Next burst address: interleaved when order is high, linear when low.
  function automatic logic [1:0] lwps_burst_next(input logic [1:0] start, input logic [1:0] cnt,
                                                 input logic order);
    return order ? (start ^ cnt) : 2'(start + cnt);
  endfunction : lwps_burst_next
endpackage : lwps_pkg

//--- core/lwps_if.sv
// Pin-level carrier joining the memory and its host.
`timescale 1ns/1ps
interface lwps_if;
  import lwps_pkg::*;
  // ==========================================================================
  // Command pins driven by the host; all are synchronous except output enable, which gates the memory's driver directly.
  logic [ADDR_W-1:0] addr;
  logic chip_select_0_n;
  logic chip_select_1;
  logic chip_select_2_n;
  logic advance_or_load;
  logic rd_wr_n;
  logic byte_lane_a_wr_n;
  logic byte_lane_b_wr_n;
  logic clock_hold_n;
  logic out_en_n;
  logic burst_order_sel_n;
  // Data bus: each end drives its own copy with an enable.
  logic [DATA_W-1:0] dq_host_o;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_mem_o;
  logic dq_mem_oe;
  logic [DATA_W-1:0] dq;
  // Resolved bus level; an undriven bus reads as zero here.
  assign dq = dq_mem_oe ? dq_mem_o : (dq_host_oe ? dq_host_o : '0);
  modport mem (input addr, chip_select_0_n, chip_select_1, chip_select_2_n, advance_or_load, rd_wr_n,
               byte_lane_a_wr_n, byte_lane_b_wr_n, clock_hold_n, out_en_n, burst_order_sel_n, dq,
               output dq_mem_o, dq_mem_oe);
  modport host (output addr, chip_select_0_n, chip_select_1, chip_select_2_n, advance_or_load, rd_wr_n,
                byte_lane_a_wr_n, byte_lane_b_wr_n, clock_hold_n, out_en_n, burst_order_sel_n,
                dq_host_o, dq_host_oe, input dq);
endinterface : lwps_if

//--- core/lwps_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module lwps_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Fill side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================================
  // Storage and pointers; the count is one bit wider to tell full from empty.
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  // Ready until the count reaches the depth; the wider count keeps full apart from empty.
  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && o_out_valid && i_out_ready;
  // Write side; the array itself needs no reset.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end
  // Pointer and occupancy bookkeeping.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule : lwps_fifo

//--- core/lwps_mem.sv
// Late-write pipelined synchronous static memory, 1M x 18.
//
// Notes on behaviour
// - Write data captured two cycles after command.
// - Read data appears two cycles after command.
// - Reads and writes mix back to back.
// - Host drives read/write low to write.
// - Each byte enable gates its own lane.
// - Write controls and address registered together.
// - Output enable may stay low always.
// - Any chip select deselecting floats the outputs.
// - Issued operations finish after deselect, the last one cycle after it.
// - Advance ignores address, selects and read/write pins, steps burst counter.
// - Clock hold high freezes every stage.
// - Array of 1M words, 18 bits each.
// - Load cycle: high reads, low writes.
// - Burst order interleaved high, linear low.
// - Output enable inactive never drives pins.
// - Chip selects sampled only in load cycles.
`timescale 1ns/1ps
module lwps_mem (
  // Clock, reset and clock enable.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Pins from the host.
  lwps_if.mem bus
);
  import lwps_pkg::*;
  // ==========================================================================
  // Storage
  logic [DATA_W-1:0] array_r [DEPTH];
  // ==========================================================================
  // Burst state, remembered from the last load cycle.
  logic [ADDR_W-1:0] base_r;
  logic [1:0] bcnt_r;
  logic sel_r;
  logic wr_r;
  logic [1:0] bw_r;
  // Two pipeline stages: command taken, and one cycle later.
  lwps_stage_t st1_r;
  lwps_stage_t st2_r;
  lwps_stage_t st_nxt;
  logic [DATA_W-1:0] q_r;
  logic q_vld_r;
  logic step;
  logic cs_on;
  logic [1:0] bcnt_nxt;
  // Clock hold high masks the edge for every process, the way the pin does.
  assign step = i_ce && !bus.clock_hold_n;
  // All three selects must agree for the device to be selected.
  assign cs_on = !bus.chip_select_0_n && bus.chip_select_1 && !bus.chip_select_2_n;
  assign bcnt_nxt = 2'(bcnt_r + 1'b1);
  // Decode this cycle's operation into a stage record.
  always_comb begin
    st_nxt = '0;
    if (!bus.advance_or_load) begin
      // New address and selects are only looked at here.
      st_nxt.valid = cs_on;
      st_nxt.wr = !bus.rd_wr_n;
      st_nxt.addr = bus.addr;
      st_nxt.bw_n = {bus.byte_lane_b_wr_n, bus.byte_lane_a_wr_n};
    end else begin
      // Continue the current burst and operation type; address, selects and read/write pins ignored.
      st_nxt.valid = sel_r;
      st_nxt.wr = wr_r;
      st_nxt.addr = {base_r[ADDR_W-1:2], lwps_burst_next(base_r[1:0], bcnt_nxt, bus.burst_order_sel_n)};
      st_nxt.bw_n = wr_r ? {bus.byte_lane_b_wr_n, bus.byte_lane_a_wr_n} : bw_r;
    end
  end
  // Burst bookkeeping: loads restart, advances step the counter.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_r <= '0;
      bcnt_r <= '0;
      sel_r <= 1'b0;
      wr_r <= 1'b0;
      bw_r <= 2'h3;
    end else if (step) begin
      if (!bus.advance_or_load) begin
        base_r <= bus.addr;
        bcnt_r <= '0;
        sel_r <= cs_on;
        wr_r <= !bus.rd_wr_n;
        bw_r <= st_nxt.bw_n;
      end else begin
        bcnt_r <= bcnt_nxt;
      end
    end
  end
  // The pipeline carries issued operations forward even after a deselect.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st1_r <= '0;
      st2_r <= '0;
    end else if (step) begin
      st1_r <= st_nxt;
      st2_r <= st1_r;
    end
  end
  // Late write: data on the bus now belongs to the command two edges back.
  always_ff @(posedge i_core_clk) begin
    if (step && st2_r.valid && st2_r.wr) begin
      if (!st2_r.bw_n[0]) begin
        array_r[st2_r.addr][LANE_A_HI:0] <= bus.dq[LANE_A_HI:0];
      end
      if (!st2_r.bw_n[1]) begin
        array_r[st2_r.addr][DATA_W-1:LANE_B_LO] <= bus.dq[DATA_W-1:LANE_B_LO];
      end
    end
  end
  // Output register: read data out one edge after the read was taken.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_r <= '0;
      q_vld_r <= 1'b0;
    end else if (step) begin
      q_vld_r <= st1_r.valid && !st1_r.wr;
      q_r <= array_r[st1_r.addr];
    end
  end
  // Output enable is asynchronous: it gates the driver with no clock.
  assign bus.dq_mem_o = q_r;
  assign bus.dq_mem_oe = q_vld_r && !bus.out_en_n;
endmodule : lwps_mem

//--- core/lwps_host.sv
// Host controller: register port in, memory pins out, FIFO on read data.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module lwps_host (
  // Clock, reset and clock enable.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Memory pins.
  lwps_if.host bus
);
  import lwps_pkg::*;
  // ==========================================================================
  // Registers of the host.
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [2:0] ctrl_r;
  logic [31:0] rdata_r;
  // Write data waits three host edges: one until the memory takes the load, two more to the data slot.
  logic [DATA_W-1:0] wd1_r;
  logic [DATA_W-1:0] wd2_r;
  logic [DATA_W-1:0] wd3_r;
  logic [2:0] wv_r;
  logic [2:0] rv_r;
  // Command pin registers.
  logic adv_r;
  logic rw_r;
  logic cs_r;
  logic [1:0] bw_r;
  logic burst_wr_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic issue;
  logic fifo_pop;
  // A command, read or write, is only taken while the read FIFO is not full; reads still in flight are not counted.
  assign issue = i_wr && (i_addr == REG_CMD) && fifo_in_ready;
  assign fifo_pop = i_rd && (i_addr == REG_RDATA);
  // Software-visible registers.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_r <= '0;
      wdata_r <= '0;
      ctrl_r <= CTRL_RST;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        REG_ADDR: addr_r <= i_wdata[ADDR_W-1:0];
        REG_WDATA: wdata_r <= i_wdata[DATA_W-1:0];
        REG_CTRL: ctrl_r <= i_wdata[2:0];
        default: ;
      endcase
    end
  end
  // Drive one command cycle per accepted order, deselect otherwise.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      adv_r <= 1'b0;
      rw_r <= 1'b1;
      cs_r <= 1'b0;
      bw_r <= 2'h3;
      burst_wr_r <= 1'b0;
    end else if (i_ce) begin
      adv_r <= 1'b0;
      cs_r <= 1'b0;
      rw_r <= 1'b1;
      bw_r <= 2'h3;
      if (issue) begin
        case (i_wdata[CMD_HI:CMD_LO])
          CMD_READ: begin
            cs_r <= 1'b1;
            burst_wr_r <= 1'b0;
          end
          CMD_WRITE: begin
            cs_r <= 1'b1;
            rw_r <= 1'b0;
            bw_r <= i_wdata[CMD_BW_HI:CMD_BW_LO];
            burst_wr_r <= 1'b1;
          end
          CMD_BURST: begin
            adv_r <= 1'b1;
            bw_r <= burst_wr_r ? i_wdata[CMD_BW_HI:CMD_BW_LO] : 2'h3;
          end
          default: ;
        endcase
      end
    end
  end
  // Track data slots; they advance only on edges the memory also sees.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wv_r <= '0;
      rv_r <= '0;
      wd1_r <= '0;
      wd2_r <= '0;
      wd3_r <= '0;
    end else if (i_ce && !ctrl_r[CTRL_HOLD]) begin
      // The order is taken one edge before the memory sees its load, hence three stages.
      wv_r <= {wv_r[1:0], issue && ((i_wdata[CMD_HI:CMD_LO] == CMD_WRITE) ||
               (i_wdata[CMD_HI:CMD_LO] == CMD_BURST && burst_wr_r))};
      rv_r <= {rv_r[1:0], issue && ((i_wdata[CMD_HI:CMD_LO] == CMD_READ) ||
               (i_wdata[CMD_HI:CMD_LO] == CMD_BURST && !burst_wr_r))};
      wd1_r <= wdata_r;
      wd2_r <= wd1_r;
      wd3_r <= wd2_r;
    end
  end
  // Read data register for the port, one cycle after the strobe.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_r <= '0;
    end else if (i_ce && i_rd) begin
      case (i_addr)
        REG_ADDR: rdata_r <= 32'(addr_r);
        REG_WDATA: rdata_r <= 32'(wdata_r);
        REG_STATUS: rdata_r <= {29'h0, fifo_out_valid, fifo_in_ready, |{wv_r, rv_r}};
        REG_RDATA: rdata_r <= fifo_out_valid ? 32'(fifo_out_data) : 32'h0;
        REG_CTRL: rdata_r <= 32'(ctrl_r);
        default: rdata_r <= 32'h0;
      endcase
    end
  end
  // Read results land two slots after their command.
  lwps_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce && !ctrl_r[CTRL_HOLD]),
    .i_in_valid(rv_r[2]),
    .i_in_data(bus.dq),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );
  // Pin drive; output enable follows the control register bit, the memory turns the bus round.
  assign o_rdata = rdata_r;
  assign bus.addr = addr_r;
  assign bus.chip_select_0_n = !cs_r;
  assign bus.chip_select_1 = cs_r;
  assign bus.chip_select_2_n = !cs_r;
  assign bus.advance_or_load = adv_r;
  assign bus.rd_wr_n = rw_r;
  assign bus.byte_lane_a_wr_n = bw_r[0];
  assign bus.byte_lane_b_wr_n = bw_r[1];
  // The hold pin is high to freeze the memory, so it follows the hold bit as it is.
  assign bus.clock_hold_n = ctrl_r[CTRL_HOLD];
  assign bus.out_en_n = ctrl_r[CTRL_OE];
  assign bus.burst_order_sel_n = ctrl_r[CTRL_ORDER];
  assign bus.dq_host_o = wd3_r;
  assign bus.dq_host_oe = wv_r[2];
endmodule : lwps_host

//--- tb/lwps_props.sv
// Pin-level checks on the link between the memory and its host.
`timescale 1ns/1ps
module lwps_props (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command pins from the host.
  input wire logic chip_select_0_n,
  input wire logic chip_select_1,
  input wire logic chip_select_2_n,
  input wire logic advance_or_load,
  input wire logic rd_wr_n,
  input wire logic clock_hold_n,
  input wire logic out_en_n,
  // Data bus drive enables.
  input wire logic dq_host_oe,
  input wire logic dq_mem_oe
);
  // ==========================================================================
  // Decoded cycle kinds.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // All three selects active at once.
  wire logic sel = !chip_select_0_n && chip_select_1 && !chip_select_2_n;
  // An edge the memory really takes; a held edge counts as absent.
  wire logic run = !clock_hold_n;
  // Load cycles by kind, only on edges that step.
  wire logic ld_rd = !advance_or_load && sel && rd_wr_n && run && !out_en_n;
  wire logic ld_wr = !advance_or_load && sel && !rd_wr_n && run;
  wire logic ld_dsl = !advance_or_load && !sel && run && !out_en_n;
  wire logic ld_nord = !advance_or_load && !(sel && rd_wr_n) && run;
  // ==========================================================================
  // Assertions.
  a_read_two_cycles: assert property (ld_rd ##1 (run && !out_en_n) |=> dq_mem_oe)
    else $error("read data not driven two cycles after its load");
  a_write_data_slot: assert property (ld_wr ##1 run |=> dq_host_oe && !dq_mem_oe)
    else $error("write data slot not two cycles after its load");
  a_read_then_write: assert property (ld_rd ##1 ld_wr ##1 (run && !out_en_n)
    |-> dq_mem_oe ##1 (dq_host_oe && !dq_mem_oe))
    else $error("read followed by write lost a bus slot");
  a_oe_blocks_drive: assert property (out_en_n |-> !dq_mem_oe)
    else $error("memory drives data with output enable inactive");
  a_bus_one_driver: assert property (!(dq_mem_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  a_desel_drains: assert property (ld_rd ##1 ld_dsl |=> dq_mem_oe)
    else $error("pending read dropped by a deselect");
  a_desel_floats: assert property (ld_nord ##1 ld_nord |=> !dq_mem_oe)
    else $error("memory drives data with no read pending");
  a_burst_continues: assert property (ld_rd ##1 (advance_or_load && run && !out_en_n)
    ##1 (run && !out_en_n) |=> dq_mem_oe)
    else $error("burst advance did not continue the read");
  a_hold_freezes: assert property (clock_hold_n ##1 $stable(out_en_n) |-> $stable(dq_mem_oe))
    else $error("memory output moved on a held edge");
endmodule : lwps_props

//--- tb/tb.sv
// Self-checking bench for the memory and its host joined pin to pin.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h, expected %h", $time, (got), (exp)); end end
module tb;
  import lwps_pkg::*;
  // ==========================================================================
  // Stimulus and bookkeeping.
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [31:0] v;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [19:0] BASE = 20'h00100;
  // Edge addresses catch aliasing of the top address bits.
  logic [19:0] adr [5] = '{20'h00000, 20'h00001, 20'h5a5a5, 20'h80001, 20'hfffff};
  always #5 i_core_clk = ~i_core_clk;
  // ==========================================================================
  // Both ends meet on one carrier; the checker watches it.
  lwps_if bus_if();
  lwps_host lwps_host_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(bus_if));
  lwps_mem lwps_mem_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .bus(bus_if));
  lwps_props lwps_props_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .chip_select_0_n(bus_if.chip_select_0_n), .chip_select_1(bus_if.chip_select_1),
    .chip_select_2_n(bus_if.chip_select_2_n), .advance_or_load(bus_if.advance_or_load),
    .rd_wr_n(bus_if.rd_wr_n), .clock_hold_n(bus_if.clock_hold_n), .out_en_n(bus_if.out_en_n),
    .dq_host_oe(bus_if.dq_host_oe), .dq_mem_oe(bus_if.dq_mem_oe));
  // ==========================================================================
  // Register port tasks; every call starts and ends just after a rising edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr
  // Read data appear in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    d = o_rdata;
    @(posedge i_core_clk);
  endtask : rd
  // Command words on consecutive edges, so the link sees them back to back.
  task automatic cmds(input logic [31:0] q [8], input int n);
    for (int k = 0; k < n; k++) begin
      i_addr <= REG_CMD;
      i_wdata <= q[k];
      i_wr <= 1'b1;
      @(posedge i_core_clk);
    end
    i_wr <= 1'b0;
    repeat (PIPE_LAT + 2) @(posedge i_core_clk);
  endtask : cmds
  function automatic logic [31:0] cw(input logic [1:0] c, input logic [1:0] bw);
    return {28'h0, bw, c};
  endfunction : cw
  // Wait, bounded, for a buffered word, then pop and compare it.
  task automatic pop(input logic [17:0] exp);
    int n;
    n = 0;
    rd(REG_STATUS, v);
    while (v[2] !== 1'b1 && n < 20) begin
      rd(REG_STATUS, v);
      n++;
    end
    rd(REG_RDATA, v);
    `CHK(v[17:0], exp)
  endtask : pop
  task automatic mw(input logic [19:0] a, input logic [17:0] d, input logic [1:0] bw);
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    cmds('{default: cw(CMD_WRITE, bw)}, 1);
  endtask : mw
  task automatic mr(input logic [19:0] a, input logic [17:0] exp);
    wr(REG_ADDR, 32'(a));
    cmds('{default: cw(CMD_READ, 2'b00)}, 1);
    pop(exp);
  endtask : mr
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // A hung handshake must not stall the run; the ceiling is far above need.
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    rd(REG_CTRL, v);
    `CHK(v[2:0], CTRL_RST)
    `CHK(bus_if.dq_mem_oe, 1'b0)
    $display("test reset done");
    foreach (adr[k]) mw(adr[k], 18'(18'h0b1c3 * (k + 1)), 2'b00);
    foreach (adr[k]) mr(adr[k], 18'(18'h0b1c3 * (k + 1)));
    $display("test addressing done");
    mw(20'h00010, 18'h3ffff, 2'b00);
    mw(20'h00010, 18'h00000, 2'b10);
    mr(20'h00010, 18'h3fe00);
    mw(20'h00010, 18'h00000, 2'b01);
    mr(20'h00010, 18'h00000);
    mw(20'h00010, 18'h3ffff, 2'b11);
    mr(20'h00010, 18'h00000);
    $display("test byte lanes done");
    // Read then write of one address on adjacent edges: old value out, new value in.
    mw(20'h00020, 18'h12345, 2'b00);
    wr(REG_WDATA, 32'h0abcd);
    cmds('{0: cw(CMD_READ, 2'b00), 1: cw(CMD_WRITE, 2'b00), default: 32'h0}, 2);
    pop(18'h12345);
    mr(20'h00020, 18'h0abcd);
    $display("test turnaround done");
    for (int k = 0; k < 4; k++) mw(BASE + 20'(k), 18'(18'h00200 + k), 2'b00);
    // Start at offset 1, where the linear and interleaved orders differ.
    for (int o = 0; o < 2; o++) begin
      wr(REG_CTRL, 32'(o));
      wr(REG_ADDR, 32'(BASE + 20'h1));
      cmds('{0: cw(CMD_READ, 2'b00), 1: cw(CMD_BURST, 2'b00), 2: cw(CMD_BURST, 2'b00),
        3: cw(CMD_BURST, 2'b00), default: 32'h0}, 4);
      for (int k = 0; k < 4; k++) pop(18'h00200 + 18'(o != 0 ? (1 ^ k) : ((1 + k) & 3)));
    end
    $display("test burst done");
    // Fill the read buffer, offer one more read, then drain it empty.
    wr(REG_ADDR, 32'(BASE));
    cmds('{default: cw(CMD_READ, 2'b00)}, FIFO_DEPTH);
    rd(REG_STATUS, v);
    `CHK(v[1], 1'b0)
    cmds('{default: cw(CMD_READ, 2'b00)}, 1);
    repeat (FIFO_DEPTH) pop(18'h00200);
    rd(REG_STATUS, v);
    `CHK(v[2], 1'b0)
    $display("test buffer done");
    // A held memory must return nothing.
    wr(REG_CTRL, 32'h3);
    cmds('{default: cw(CMD_READ, 2'b00)}, 1);
    rd(REG_STATUS, v);
    `CHK(v[2], 1'b0)
    wr(REG_CTRL, 32'h5);
    cmds('{default: cw(CMD_READ, 2'b00)}, 1);
    // The word at the base is nonzero, so a zero proves the memory left the bus undriven.
    pop(18'h00000);
    $display("test hold and output enable done");
    results();
  end
endmodule : tb
